// File: shared/afbo_pkg.sv
package afbo_pkg;
    // apb register offsets (byte addresses)
    localparam logic [7:0] afbo_reg_ctrl   = 8'h00;
    localparam logic [7:0] afbo_reg_addr   = 8'h04;
    localparam logic [7:0] afbo_reg_wdata  = 8'h08;
    localparam logic [7:0] afbo_reg_rdata  = 8'h0c;
    localparam logic [7:0] afbo_reg_status = 8'h10;
    localparam logic [7:0] afbo_reg_page   = 8'h14;
    // control register field positions
    localparam int afbo_ctrl_go_bit     = 0;
    localparam int afbo_ctrl_write_bit  = 1;
    localparam int afbo_ctrl_page_bit   = 2;
    localparam int afbo_ctrl_upper_bit  = 3;
    localparam int afbo_ctrl_wprot_bit  = 4;
    localparam int afbo_ctrl_accel_bit  = 5;
    localparam int afbo_ctrl_hwrst_bit  = 6;
    localparam int afbo_ctrl_dual_bit   = 7;
    // status register field positions
    localparam int afbo_stat_busy_bit   = 0;
    localparam int afbo_stat_rdy_bit    = 1;
    localparam int afbo_stat_bank_lsb   = 2;
    // widths
    localparam int afbo_addr_w = 23;
    localparam int afbo_data_w = 16;
    localparam int afbo_page_words = 8;
    // timing in ns and derived cycles at 50 mhz
    localparam int afbo_clk_period_ns   = 20;
    localparam int random_access_time   = 70;
    localparam int page_access_time     = 30;
    localparam int afbo_write_pulse_ns  = 40;
    localparam int afbo_recover_ns      = 30;
    localparam int afbo_reset_pulse_ns  = 500;
    localparam int afbo_reset_high_ns   = 200;
    localparam logic [4:0] afbo_acc_cyc =
        5'((random_access_time + afbo_clk_period_ns - 1) / afbo_clk_period_ns);
    localparam logic [4:0] afbo_pacc_cyc =
        5'((page_access_time + afbo_clk_period_ns - 1) / afbo_clk_period_ns);
    localparam logic [4:0] afbo_wp_cyc =
        5'((afbo_write_pulse_ns + afbo_clk_period_ns - 1) / afbo_clk_period_ns);
    localparam logic [4:0] afbo_rec_cyc =
        5'((afbo_recover_ns + afbo_clk_period_ns - 1) / afbo_clk_period_ns);
    localparam logic [4:0] afbo_rp_cyc =
        5'((afbo_reset_pulse_ns + afbo_clk_period_ns - 1) / afbo_clk_period_ns);
    localparam logic [4:0] afbo_rh_cyc =
        5'((afbo_reset_high_ns + afbo_clk_period_ns - 1) / afbo_clk_period_ns);
    // reset values
    localparam logic [31:0] afbo_ctrl_reset = 32'h0000_0000;
    // bus sequencer states
    typedef enum logic [6:0] {
        afbo_idle   = 7'h01,
        afbo_rd_acc = 7'h02,
        afbo_wr_set = 7'h04,
        afbo_wr_pul = 7'h08,
        afbo_wr_rec = 7'h10,
        afbo_rst_lo = 7'h20,
        afbo_rst_hi = 7'h40
    } afbo_state_type;
endpackage

// File: core/afbo_bank_decode.sv
`timescale 1ns/10ps
module afbo_bank_decode
    import afbo_pkg::*;
(
    input  wire logic [2:0] top_bits,
    input  wire logic       dual_mode,
    input  wire logic       upper_sel,
    output logic      [1:0] bank
);
    // bank index 0..3 from top address bits for either select variant
    always_comb
    begin
        if (!dual_mode)
        begin
            case (top_bits)
                3'h0:    bank = 2'h0;
                3'h7:    bank = 2'h3;
                3'h1, 3'h2, 3'h3: bank = 2'h1;
                default: bank = 2'h2;
            endcase
        end
        else if (!upper_sel)
            bank = (top_bits[1:0] == 2'h3) ? 2'h1 : 2'h0;
        else
            bank = (top_bits[1:0] == 2'h0) ? 2'h2 : 2'h3;
    end
endmodule

// File: core/afbo_page_cache.sv
`timescale 1ns/10ps
module afbo_page_cache
    import afbo_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [15:0] wr_data,
    input  wire logic [2:0]  rd_idx,
    output logic      [15:0] rd_data
);
    logic [15:0] mem [afbo_page_words];
    // store words captured at the end of every read, page mode or not, registered read port
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem[wr_idx] <= wr_data;
        rd_data <= mem[rd_idx];
    end
endmodule

// File: core/afbo_host.sv
`timescale 1ns/10ps
// Function
// - read: gate and select low, strobe high
// - never both selects low together
// - write: strobe and select low, gate high
// - hold protect high for boot writes
module afbo_host
    import afbo_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [22:0]      flash_addr,
    output logic [15:0]      dq_out,
    output logic             dq_oe_n,
    input  wire logic [15:0] dq_in,
    output logic             chip_select_n,
    output logic             lower_half_select_n,
    output logic             upper_half_select_n,
    output logic             output_gate_n,
    output logic             write_strobe_n,
    output logic             hw_reset_n,
    output logic             protect_accel_in,
    output logic             accel_voltage,
    input  wire logic        ready_busy_n
);
    import afbo_pkg::*;

    afbo_state_type state;
    afbo_state_type next_state;
    logic [31:0] ctrl;
    logic [22:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [4:0]  cnt;
    logic        busy;
    logic        page_valid;
    logic [19:0] page_tag;
    logic [1:0]  bank;
    logic        go;
    logic        apb_wr;
    logic        rdy_s;
    logic [15:0] cache_q;
    logic        cache_we;
    logic        acc_done;
    logic [31:0] live_ctrl;

    assign apb_wr = psel && penable && pwrite;
    assign go = apb_wr && (paddr == afbo_reg_ctrl) && pwdata[afbo_ctrl_go_bit] && !busy;
    assign acc_done = (cnt == 5'h00);
    // control word in force: the one being written on a go edge, else the stored one
    assign live_ctrl = go ? pwdata : ctrl;

    afbo_bank_decode u_bank (
        .top_bits  (addr_reg[22:20]),
        .dual_mode (ctrl[afbo_ctrl_dual_bit]),
        .upper_sel (ctrl[afbo_ctrl_upper_bit]),
        .bank      (bank)
    );

    afbo_page_cache u_cache (
        .core_clk (core_clk),
        .wr_en    (cache_we),
        .wr_idx   (addr_reg[2:0]),
        .wr_data  (dq_in),
        .rd_idx   (addr_reg[2:0]),
        .rd_data  (cache_q)
    );

    // apb slave: zero wait state, registers written in access phase
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctrl      <= afbo_ctrl_reset;
            addr_reg  <= 23'h000000;
            wdata_reg <= 16'h0000;
        end
        else if (apb_wr && !busy)
        begin
            case (paddr)
                afbo_reg_ctrl:  ctrl <= pwdata;
                afbo_reg_addr:  addr_reg <= pwdata[22:0];
                afbo_reg_wdata: wdata_reg <= pwdata[15:0];
                default: ;
            endcase
        end
        else if (apb_wr && paddr == afbo_reg_ctrl)
            ctrl <= {ctrl[31:1], 1'b0};
    end

    // apb read mux and response
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr > afbo_reg_page || paddr[1:0] != 2'h0);
            case (paddr)
                afbo_reg_ctrl:   prdata <= ctrl;
                afbo_reg_addr:   prdata <= {9'h000, addr_reg};
                afbo_reg_wdata:  prdata <= {16'h0000, wdata_reg};
                afbo_reg_rdata:  prdata <= {16'h0000, rdata_reg};
                afbo_reg_status: prdata <= {28'h0000000, bank, rdy_s, busy};
                afbo_reg_page:   prdata <= {11'h000, page_valid, page_tag};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ready/busy sampled for status; device holds it low while busy
    always_ff @(posedge core_clk)
    begin
        if (reset)
            rdy_s <= 1'b1;
        else
            rdy_s <= ready_busy_n;
    end

    // bus sequencer transitions
    always_comb
    begin
        next_state = state;
        case (state)
            afbo_idle:
                if (go && pwdata[afbo_ctrl_hwrst_bit])
                    next_state = afbo_rst_lo;
                else if (go && pwdata[afbo_ctrl_write_bit])
                    next_state = afbo_wr_set;
                else if (go)
                    next_state = afbo_rd_acc;
            afbo_rd_acc: if (acc_done) next_state = afbo_idle;
            afbo_wr_set: next_state = afbo_wr_pul;
            afbo_wr_pul: if (acc_done) next_state = afbo_wr_rec;
            afbo_wr_rec: if (acc_done) next_state = afbo_idle;
            afbo_rst_lo: if (acc_done) next_state = afbo_rst_hi;
            afbo_rst_hi: if (acc_done) next_state = afbo_idle;
            default: next_state = afbo_idle;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            state <= afbo_idle;
        else
            state <= next_state;
    end

    assign busy = (state != afbo_idle);

    // wait counter; page hits use the short access time
    always_ff @(posedge core_clk)
    begin
        if (reset)
            cnt <= 5'h00;
        else if (state == afbo_idle && go)
        begin
            if (pwdata[afbo_ctrl_hwrst_bit])
                cnt <= afbo_rp_cyc;
            else if (pwdata[afbo_ctrl_write_bit])
                cnt <= afbo_wp_cyc;
            else if (page_valid && page_tag == addr_reg[22:3])
                cnt <= afbo_pacc_cyc;
            else
                cnt <= afbo_acc_cyc;
        end
        else if (state == afbo_wr_pul && acc_done)
            cnt <= afbo_rec_cyc;
        else if (state == afbo_rst_lo && acc_done)
            cnt <= afbo_rh_cyc;
        else if (!acc_done)
            cnt <= cnt - 5'h01;
    end

    // page tracking: selects dropping or writes or reset end the page
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            page_valid <= 1'b0;
            page_tag   <= 20'h00000;
        end
        else if (state == afbo_rd_acc && acc_done)
        begin
            page_valid <= ctrl[afbo_ctrl_page_bit];
            page_tag   <= addr_reg[22:3];
        end
        else if (state == afbo_wr_set || state == afbo_rst_lo)
            page_valid <= 1'b0;
        else if (state == afbo_idle && !ctrl[afbo_ctrl_page_bit])
            page_valid <= 1'b0;
    end

    assign cache_we = (state == afbo_rd_acc) && acc_done;

    // read data capture at end of access time
    always_ff @(posedge core_clk)
    begin
        if (reset)
            rdata_reg <= 16'h0000;
        else if (cache_we)
            rdata_reg <= dq_in;
    end

    // pin drivers, all registered
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            flash_addr          <= 23'h000000;
            dq_out              <= 16'h0000;
            dq_oe_n             <= 1'b1;
            chip_select_n       <= 1'b1;
            lower_half_select_n <= 1'b1;
            upper_half_select_n <= 1'b1;
            output_gate_n       <= 1'b1;
            write_strobe_n      <= 1'b1;
            hw_reset_n          <= 1'b1;
            protect_accel_in    <= 1'b0;
            accel_voltage       <= 1'b0;
        end
        else
        begin
            flash_addr       <= addr_reg;
            protect_accel_in <= live_ctrl[afbo_ctrl_wprot_bit]
                                || live_ctrl[afbo_ctrl_accel_bit];
            accel_voltage    <= live_ctrl[afbo_ctrl_accel_bit];
            hw_reset_n       <= (next_state != afbo_rst_lo);
            case (next_state)
                afbo_rd_acc:
                begin
                    output_gate_n  <= 1'b0;
                    write_strobe_n <= 1'b1;
                    dq_oe_n        <= 1'b1;
                end
                afbo_wr_set, afbo_wr_rec:
                begin
                    output_gate_n  <= 1'b1;
                    write_strobe_n <= 1'b1;
                    dq_oe_n        <= 1'b0;
                    dq_out         <= wdata_reg;
                end
                afbo_wr_pul:
                begin
                    output_gate_n  <= 1'b1;
                    write_strobe_n <= 1'b0;
                    dq_oe_n        <= 1'b0;
                end
                default:
                begin
                    output_gate_n  <= 1'b1;
                    write_strobe_n <= 1'b1;
                    dq_oe_n        <= 1'b1;
                end
            endcase
            // selects held low through reads, writes and page runs, else released for standby;
            // a page read ending keeps them low so the open page is not lost
            if (next_state == afbo_rd_acc || next_state == afbo_wr_set
                || next_state == afbo_wr_pul || next_state == afbo_wr_rec
                || (next_state == afbo_idle && live_ctrl[afbo_ctrl_page_bit]
                    && (page_valid || state == afbo_rd_acc)))
            begin
                chip_select_n       <= live_ctrl[afbo_ctrl_dual_bit];
                lower_half_select_n <= !live_ctrl[afbo_ctrl_dual_bit]
                                       || live_ctrl[afbo_ctrl_upper_bit];
                upper_half_select_n <= !live_ctrl[afbo_ctrl_dual_bit]
                                       || !live_ctrl[afbo_ctrl_upper_bit];
            end
            else
            begin
                chip_select_n       <= 1'b1;
                lower_half_select_n <= 1'b1;
                upper_half_select_n <= 1'b1;
            end
        end
    end
endmodule

// File: verification/afbo_flash_model.sv
`timescale 1ns/10ps
module afbo_flash_model
    import afbo_pkg::*;
#(
    parameter int slow_ns = 70,
    parameter int fast_ns = 30
)
(
    input  wire logic [22:0] flash_addr,
    input  wire logic [15:0] dq_out,
    input  wire logic        dq_oe_n,
    output logic      [15:0] dq_in,
    input  wire logic        chip_select_n,
    input  wire logic        lower_half_select_n,
    input  wire logic        upper_half_select_n,
    input  wire logic        output_gate_n,
    input  wire logic        write_strobe_n,
    input  wire logic        hw_reset_n,
    output logic             ready_busy_n
);
    logic        sel;
    logic        rd_on;
    logic        slow_ok;
    logic        fast_ok;
    logic        page_hit = 1'b0;
    logic        busy = 1'b0;
    logic [19:0] open_page = '0;
    logic [22:0] cmd_addr = '0;
    logic [15:0] cmd_data = '0;
    logic [15:0] word;
    int          resets = 0;
    // any select low enables the device
    assign sel = !chip_select_n || !lower_half_select_n || !upper_half_select_n;
    // array read: select and gate low, strobe and reset high, even while busy
    assign rd_on = sel && !output_gate_n && write_strobe_n && hw_reset_n;
    assign #(slow_ns) slow_ok = rd_on;
    assign #(fast_ns) fast_ok = rd_on;
    // stored word depends on page and word index
    assign word = flash_addr[15:0] ^ {flash_addr[22:20], 13'h01a5};
    // data not yet valid or outputs floating show the inverse
    assign dq_in = (rd_on && (slow_ok || (page_hit && fast_ok))) ? word : ~word;
    // page stays open only while selected and on the same page
    always @*
    begin
        if (!sel)
            page_hit = 1'b0;
        else if (rd_on && slow_ok)
        begin
            page_hit  = 1'b1;
            open_page = flash_addr[22:3];
        end
        else if (flash_addr[22:3] != open_page)
            page_hit = 1'b0;
    end
    // command latch: address on strobe fall, data on rise, ignored in reset
    always @(negedge write_strobe_n)
        if (sel && hw_reset_n)
            cmd_addr = flash_addr;
    always @(posedge write_strobe_n)
        if (sel && hw_reset_n)
        begin
            cmd_data = dq_out;
            busy     = 1'b1;
            busy <= #300 1'b0;
        end
    // reset aborts the running operation
    always @(negedge hw_reset_n)
    begin
        resets++;
        busy = 1'b0;
    end
    // open-drain busy, low while operating or in reset
    assign ready_busy_n = !(busy || !hw_reset_n);
endmodule

// File: verification/afbo_host_props.sv
`timescale 1ns/10ps
module afbo_host_props
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [22:0] flash_addr,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe_n,
    input wire logic        chip_select_n,
    input wire logic        lower_half_select_n,
    input wire logic        upper_half_select_n,
    input wire logic        output_gate_n,
    input wire logic        write_strobe_n,
    input wire logic        hw_reset_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_read_strobe_high: assert property (!output_gate_n |-> write_strobe_n)
        else $error("gate and strobe low together");
    a_no_contention: assert property (!dq_oe_n |-> output_gate_n)
        else $error("host drives data while gate low");
    a_write_gate_high: assert property (!write_strobe_n |-> output_gate_n && !dq_oe_n)
        else $error("write without gate high and data driven");
    a_write_selected: assert property (!write_strobe_n |->
        (!chip_select_n || !lower_half_select_n || !upper_half_select_n))
        else $error("strobe low with no select");
    a_dual_exclusive: assert property (lower_half_select_n || upper_half_select_n)
        else $error("both half selects low");
    a_write_hold: assert property (!write_strobe_n |-> $stable(flash_addr) && $stable(dq_out))
        else $error("address or data moved during strobe");
    a_strobe_width: assert property ($fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
        else $error("strobe pulse not two cycles");
    a_reset_pulse: assert property ($fell(hw_reset_n) |->
        (!hw_reset_n)[*8] ##18 !hw_reset_n ##1 hw_reset_n)
        else $error("hardware reset pulse wrong length");
    a_idle_after_reset: assert property ($fell(reset) |->
        chip_select_n && output_gate_n && write_strobe_n && hw_reset_n && dq_oe_n)
        else $error("bus not idle after reset");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");
    c_write: cover property ($fell(write_strobe_n));
    c_reset: cover property ($fell(hw_reset_n));
    c_dual_read: cover property (!output_gate_n && !upper_half_select_n);
endmodule

// File: verification/afbo_host_bench.sv
`timescale 1ns/10ps
module afbo_host_bench;
    import afbo_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = '0;
    logic [31:0] pwdata   = '0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, e;
    logic [22:0] flash_addr;
    logic [15:0] dq_out, dq_in;
    logic        dq_oe_n, chip_select_n, lower_half_select_n, upper_half_select_n;
    logic        output_gate_n, write_strobe_n, hw_reset_n, protect_accel_in;
    logic        accel_voltage, ready_busy_n;
    int          n_fail  = 0;
    int          n_tests = 0;
    logic [22:0] sa [4] = '{23'h000012, 23'h1abcd5, 23'h6f0007, 23'h7ffff9};
    logic [22:0] da [4] = '{23'h2a0010, 23'h3f00a3, 23'h012344, 23'h1ffffe};
    logic [31:0] dc [4] = '{32'h80, 32'h80, 32'h88, 32'h88};
    always #10 core_clk = ~core_clk;
    afbo_host dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .flash_addr, .dq_out, .dq_oe_n, .dq_in, .chip_select_n,
        .lower_half_select_n, .upper_half_select_n, .output_gate_n, .write_strobe_n,
        .hw_reset_n, .protect_accel_in, .accel_voltage, .ready_busy_n);
    afbo_flash_model flash (.flash_addr, .dq_out, .dq_oe_n, .dq_in, .chip_select_n,
        .lower_half_select_n, .upper_half_select_n, .output_gate_n, .write_strobe_n,
        .hw_reset_n, .ready_busy_n);
    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer: setup, access until pready
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // start a flash cycle and poll status until idle
    task run(input logic [31:0] ctrl);
        xfer(1'b1, afbo_reg_ctrl, ctrl | 32'h1);
        do
            xfer(1'b0, afbo_reg_status, 32'h0);
        while (q[afbo_stat_busy_bit] !== 1'b0);
    endtask
    task flash_read(input logic [22:0] a, input logic [31:0] ctrl, input logic [1:0] bank);
        xfer(1'b1, afbo_reg_addr, {9'h0, a});
        run(ctrl);
        check(32'(q[3:2]), 32'(bank));
        xfer(1'b0, afbo_reg_rdata, 32'h0);
        check({16'h0, q[15:0]}, {16'h0, a[15:0] ^ {a[22:20], 13'h01a5}});
    endtask
    // main sequence
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        xfer(1'b0, afbo_reg_ctrl, 32'h0);
        check(q, afbo_ctrl_reset);
        check(32'({chip_select_n, output_gate_n, hw_reset_n, dq_oe_n}), 32'hf);
        xfer(1'b0, 8'h18, 32'h0);
        check(32'(e), 32'h1);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
            flash_read(sa[i], 32'h0, 2'(i));
        for (int i = 0; i < 4; i++)
            flash_read(da[i], dc[i], 2'(i));
        $display("test bank reads done");
        flash_read(23'h155551, 32'h4, 2'h1);
        flash_read(23'h155556, 32'h4, 2'h1);
        flash_read(23'h155568, 32'h4, 2'h1);
        flash_read(23'h155569, 32'h0, 2'h1);
        $display("test page reads done");
        xfer(1'b1, afbo_reg_addr, 32'h0002a6);
        xfer(1'b1, afbo_reg_wdata, 32'hc3e1);
        run(32'h32);
        check(32'(q[afbo_stat_rdy_bit]), 32'h0);
        check(32'({protect_accel_in, accel_voltage}), 32'h3);
        check(32'(flash.cmd_addr), 32'h0002a6);
        check(32'(flash.cmd_data), 32'hc3e1);
        xfer(1'b1, afbo_reg_addr, 32'h7ff001);
        xfer(1'b1, afbo_reg_wdata, 32'h0f5a);
        run(32'h12);
        check(32'({protect_accel_in, accel_voltage}), 32'h2);
        check(32'(flash.cmd_data), 32'h0f5a);
        flash_read(23'h2000a1, 32'h0, 2'h1);
        repeat (20) @(posedge core_clk);
        xfer(1'b0, afbo_reg_status, 32'h0);
        check(32'(q[afbo_stat_rdy_bit]), 32'h1);
        $display("test writes done");
        run(32'h40);
        check(32'(flash.resets), 32'h1);
        flash_read(23'h000012, 32'h0, 2'h0);
        $display("test hardware reset done");
        test_done;
    end
    // watchdog well beyond the expected run of a few hundred cycles
    initial
    begin
        #200000;
        n_fail++;
        test_done;
    end
endmodule
bind afbo_host afbo_host_props props (.core_clk, .reset, .psel, .penable, .pready, .flash_addr,
    .dq_out, .dq_oe_n, .chip_select_n, .lower_half_select_n, .upper_half_select_n,
    .output_gate_n, .write_strobe_n, .hw_reset_n);
